// >>> rtl/pbs_defs.svh
// constants for the pipelined burst sram port
//
// Functional notes
// - clock qualifier high freezes all state but the sleep sequencer and strap sync
// - inputs sampled, read data launched, rising edge
// - read: qualified, all selected, strobe high, load
// - read data after next edge, needs drive enable
// - new command accepted right after a read
// - deselect tristates outputs after next edge
// - four-beat burst on two low address bits
// - order select low linear, high interleaved
// - interleave xors beat, linear adds modulo four
// - step input advances counter, ignores selects
// - burst keeps read or write type
// - controller loads address after deselect
// - write: qualified, selected, strobe low, latch lanes
// - edge after write tristates, next command accepted
// - write data captured two edges after command
// - only selected lanes and parity are written
// - sleep input enters low power, keeps contents
// - sleep entry and exit take two cycles
// - powers up deselected with outputs tristated
// - first clock after deselect keeps outputs off
`ifndef PBS_DEFS_SVH
`define PBS_DEFS_SVH
`define PBS_ADDR_W 19
`define PBS_LANES 4
`define PBS_LANE_W 8
`define PBS_SLEEP_CYCLES 2
`define PBS_BEAT_RESET 2'h0
`define PBS_ORDER_RESET 1'b1
`endif

// >>> rtl/pbs_pkg.sv
// types shared by the pipelined burst sram port
package pbs_pkg;
  typedef logic [18:0] pbs_addr_t;
  typedef enum logic [1:0]
  {
    PBS_AWAKE = 2'b00,
    PBS_ENTER = 2'b01,
    PBS_ASLEEP = 2'b10,
    PBS_LEAVE = 2'b11
  } pbs_sleep_e;
endpackage : pbs_pkg

// >>> rtl/pbs_burst_order.sv
// low address bits of one burst beat
`timescale 1ns/1ps
`default_nettype none
module pbs_burst_order
(
  // burst start and position
  input wire logic [1:0] startBits,
  input wire logic [1:0] beatCount,
  // order select, high is interleaved
  input wire logic interleave,
  // address bits for this beat
  output logic [1:0] beatBits
);
  // both orders wrap inside the group of four
  always_comb
  begin
    if (interleave)
      beatBits = startBits ^ beatCount;
    else
      beatBits = 2'(startBits + beatCount);
  end
endmodule : pbs_burst_order
`default_nettype wire

// >>> rtl/pbs_sleep_ctl.sv
// sleep synchroniser and entry/exit sequencer
`timescale 1ns/1ps
`default_nettype none
module pbs_sleep_ctl
  import pbs_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // asynchronous sleep pin
  input wire logic sleepRequest,
  // high while not fully awake
  output logic sleeping
);
`include "pbs_defs.svh"
  logic syncA;
  logic syncB;
  pbs_sleep_e state;
  logic [1:0] phaseCount;

  // two flops before anything reads the async pin
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      syncA <= 1'b0;
      syncB <= 1'b0;
    end
    else
    begin
      syncA <= sleepRequest;
      syncB <= syncA;
    end
  end

  // each transition spends the fixed entry or exit time
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= PBS_AWAKE;
      phaseCount <= 2'h0;
    end
    else
    begin
      case (state)
        PBS_AWAKE:
          if (syncB)
          begin
            state <= PBS_ENTER;
            phaseCount <= 2'h1;
          end
        PBS_ENTER:
          if (phaseCount == 2'(`PBS_SLEEP_CYCLES))
            state <= PBS_ASLEEP;
          else
            phaseCount <= 2'(phaseCount + 2'h1);
        PBS_ASLEEP:
          if (!syncB)
          begin
            state <= PBS_LEAVE;
            phaseCount <= 2'h1;
          end
        PBS_LEAVE:
          if (phaseCount == 2'(`PBS_SLEEP_CYCLES))
            state <= PBS_AWAKE;
          else
            phaseCount <= 2'(phaseCount + 2'h1);
        default:
          state <= PBS_AWAKE;
      endcase
    end
  end

  assign sleeping = (state != PBS_AWAKE);
endmodule : pbs_sleep_ctl
`default_nettype wire

// >>> rtl/pbs_sram_port.sv
// pipelined burst sram port with zero turnaround
`timescale 1ns/1ps
`default_nettype none
module pbs_sram_port
  import pbs_pkg::*;
(
  // clock and power-up reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // address
  input wire logic [18:0] addrIn,
  // synchronous control
  input wire logic clockQualifierN,
  input wire logic chipSelect1N,
  input wire logic chipSelect2,
  input wire logic chipSelect3N,
  input wire logic writeStrobeN,
  input wire logic stepOrCapture,
  input wire logic [3:0] byteLaneSelectN,
  // burst order strap, high is interleaved
  input wire logic burstOrderSelect,
  // asynchronous controls
  input wire logic outputDriveN,
  input wire logic sleepRequest,
  // data pins
  input wire logic [31:0] dataIn,
  output logic [31:0] dataOut,
  output logic [31:0] dataOe,
  // parity pins, one per byte lane
  input wire logic [3:0] parityLaneIn,
  output logic [3:0] parityLaneOut,
  output logic [3:0] parityLaneOe
);
`include "pbs_defs.svh"

  ////////////////////////////////////////////////////////////////
  // declarations

  // timing of one command taken at qualified edge n:
  //   stage one holds it after n
  //   a read reaches the output register at n + 1
  //   a write meets its data on the pins at n + 2
  // a stalled edge leaves every stage exactly as it was

  logic sleeping;
  logic orderSyncA;
  logic orderSync;
  logic qualified;
  logic allSelected;
  logic loadCmd;
  logic newRead;
  logic newWrite;
  logic continueBeat;
  logic burstActive;
  logic burstWrite;
  pbs_addr_t burstBase;
  logic [1:0] beatCnt;
  logic [1:0] next_beatCnt;
  logic [1:0] beatBits;
  pbs_addr_t issueAddr;
  logic issueRead;
  logic issueWrite;
  logic rdValid1;
  pbs_addr_t rdAddr1;
  logic wrValid1;
  pbs_addr_t wrAddr1;
  logic [3:0] wrLanes1;
  logic wrValid2;
  pbs_addr_t wrAddr2;
  logic [3:0] wrLanes2;
  logic outActive;
  logic [3:0][8:0] readWord;
  logic [3:0][8:0] outWord;
  logic driveOn;

  ////////////////////////////////////////////////////////////////
  // sleep sequencing

  // the sequencer runs on every edge, qualified or not, so a
  // stalled controller cannot hold the block out of sleep
  // sleep is async, so the sequencer synchronises it first
  pbs_sleep_ctl u_sleep
  (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .sleepRequest(sleepRequest),
    .sleeping(sleeping)
  );

  ////////////////////////////////////////////////////////////////
  // order strap

  // strap may float at power-up, so it is synchronised
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      orderSyncA <= `PBS_ORDER_RESET;
      orderSync <= `PBS_ORDER_RESET;
    end
    else
    begin
      orderSyncA <= burstOrderSelect;
      orderSync <= orderSyncA;
    end
  end

  ////////////////////////////////////////////////////////////////
  // command decode

  // an edge counts only when qualified and awake
  assign qualified = !clockQualifierN && !sleeping;

  // all three chip selects active at once
  assign allSelected = !chipSelect1N && chipSelect2 && !chipSelect3N;

  // step low loads a fresh command
  assign loadCmd = !stepOrCapture;

  // new read and new write starts
  assign newRead = loadCmd && allSelected && writeStrobeN;
  assign newWrite = loadCmd && allSelected && !writeStrobeN;

  // a continuation with no live burst, as after a deselect,
  // issues nothing, so the controller has to reload an address
  // continuation ignores selects and strobe
  assign continueBeat = stepOrCapture && burstActive;

  ////////////////////////////////////////////////////////////////
  // burst counter

  // beat count for the continuation issued this cycle
  assign next_beatCnt = 2'(beatCnt + 2'h1);

  // low address bits in the selected order
  pbs_burst_order u_order
  (
    .startBits(burstBase[1:0]),
    .beatCount(next_beatCnt),
    .interleave(orderSync),
    .beatBits(beatBits)
  );

  // address and type presented to the core this cycle
  always_comb
  begin
    if (loadCmd)
    begin
      issueAddr = addrIn;
      issueRead = newRead;
      issueWrite = newWrite;
    end
    else
    begin
      issueAddr = {burstBase[18:2], beatBits};
      issueRead = continueBeat && !burstWrite;
      issueWrite = continueBeat && burstWrite;
    end
  end

  // burst state: base address, beat and latched type
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      burstActive <= 1'b0;
      burstWrite <= 1'b0;
      burstBase <= '0;
      beatCnt <= `PBS_BEAT_RESET;
    end
    else if (sleeping)
    begin
      // a sleep forces a fresh address load afterwards
      burstActive <= 1'b0;
    end
    else if (qualified)
    begin
      if (loadCmd && allSelected)
      begin
        burstActive <= 1'b1;
        burstWrite <= !writeStrobeN;
        burstBase <= addrIn;
        beatCnt <= `PBS_BEAT_RESET;
      end
      else if (loadCmd)
      begin
        burstActive <= 1'b0;
      end
      else if (burstActive)
      begin
        beatCnt <= next_beatCnt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // read pipeline stage one

  // every qualified edge takes a command, so reads go back to back
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdValid1 <= 1'b0;
      rdAddr1 <= '0;
    end
    else if (sleeping)
    begin
      // pending reads are dropped on sleep entry
      rdValid1 <= 1'b0;
    end
    else if (qualified)
    begin
      rdValid1 <= issueRead;
      rdAddr1 <= issueAddr;
    end
  end

  ////////////////////////////////////////////////////////////////
  // write pipeline, two stages ahead of the data

  // lanes are sampled with each beat, not once per burst
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wrValid1 <= 1'b0;
      wrAddr1 <= '0;
      wrLanes1 <= 4'h0;
    end
    else if (sleeping)
    begin
      wrValid1 <= 1'b0;
    end
    else if (qualified)
    begin
      wrValid1 <= issueWrite;
      wrAddr1 <= issueAddr;
      wrLanes1 <= ~byteLaneSelectN;
    end
  end

  // second stage lines up with the data edge
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wrValid2 <= 1'b0;
      wrAddr2 <= '0;
      wrLanes2 <= 4'h0;
    end
    else if (sleeping)
    begin
      wrValid2 <= 1'b0;
    end
    else if (qualified)
    begin
      wrValid2 <= wrValid1;
      wrAddr2 <= wrAddr1;
      wrLanes2 <= wrLanes1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // storage, one array per byte lane

  // limitation: a word is written two edges after its command,
  // so a read issued one edge after a write to the same
  // word returns the old word; there is no forwarding path

  // separate arrays keep one writer per array and let lanes
  // update alone; contents survive sleep as nothing clears them
  generate
    for (genvar lane = 0; lane < `PBS_LANES; lane++)
    begin : g_lane
      logic [8:0] laneMem [0:(1 << `PBS_ADDR_W) - 1];

      // data plus parity of one lane, taken two edges on
      always_ff @(posedge ref_clk)
      begin
        if (qualified && wrValid2 && wrLanes2[lane])
        begin
          laneMem[wrAddr2] <= {parityLaneIn[lane],
            dataIn[lane * `PBS_LANE_W +: `PBS_LANE_W]};
        end
      end

      // lane value for the read in stage one
      assign readWord[lane] = laneMem[rdAddr1];

      // split the output register back onto the pins
      assign dataOut[lane * `PBS_LANE_W +: `PBS_LANE_W] =
        outWord[lane][7:0];
      assign parityLaneOut[lane] = outWord[lane][8];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // output register

  // read data is launched one edge after the read command
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      outWord <= '0;
    end
    else if (qualified && rdValid1)
    begin
      outWord <= readWord;
    end
  end

  // drive follows stage one: writes, deselects and the first
  // clock after a deselect all leave it low
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      outActive <= 1'b0;
    end
    else if (sleeping)
    begin
      outActive <= 1'b0;
    end
    else if (qualified)
    begin
      outActive <= rdValid1;
    end
  end

  ////////////////////////////////////////////////////////////////
  // pin drivers

  // the async drive enable only masks; it never starts a drive
  // it acts without a clock, so a controller can free the lines
  // early before it turns the bus around
  assign driveOn = outActive && !outputDriveN && !sleeping;

  // enables for data and parity follow the same gate
  assign dataOe = {32{driveOn}};
  assign parityLaneOe = {4{driveOn}};
endmodule : pbs_sram_port
`default_nettype wire

// >>> bench/pbs_sram_port_props.sv
// pin-level assertions for the pipelined burst sram port
`timescale 1ns/1ps
`default_nettype none
module pbs_sram_port_props
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // command pins
  input wire logic clockQualifierN,
  input wire logic chipSelect1N,
  input wire logic chipSelect2,
  input wire logic chipSelect3N,
  input wire logic writeStrobeN,
  input wire logic stepOrCapture,
  // asynchronous pins
  input wire logic outputDriveN,
  input wire logic sleepRequest,
  // read side
  input wire logic [31:0] dataOut,
  input wire logic [31:0] dataOe,
  input wire logic [3:0] parityLaneOe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic [3:0] awake;
  logic quiet;
  logic sel;
  logic load;
  //////////////////////////////
  // sleep drops commands, so only commands well clear of a sleep request are judged
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
      awake <= 4'hf;
    else if (sleepRequest)
      awake <= 4'h0;
    else if (!quiet)
      awake <= awake + 4'h1;
  // decoded command at a qualified edge
  assign quiet = awake == 4'hf;
  assign sel = !chipSelect1N && chipSelect2 && !chipSelect3N;
  assign load = !clockQualifierN && !stepOrCapture && quiet;
  //////////////////////////////
  // output enable and data relations
  property p_reset_off; $rose(rst_b) |-> dataOe == 32'h0; endproperty
  a_reset_off: assert property (p_reset_off) else $error("drive on after reset");
  property p_drive_off; outputDriveN |-> dataOe == 32'h0 && parityLaneOe == 4'h0; endproperty
  a_drive_off: assert property (p_drive_off) else $error("drive while enable high");
  property p_lanes_same; parityLaneOe == {4{dataOe[0]}} && dataOe == {32{dataOe[0]}}; endproperty
  a_lanes_same: assert property (p_lanes_same) else $error("lane enables differ");
  property p_read_out;
    load && sel && writeStrobeN ##1 !clockQualifierN |=> outputDriveN || dataOe == '1;
  endproperty
  a_read_out: assert property (p_read_out) else $error("read data not driven");
  property p_write_off; load && sel && !writeStrobeN ##1 !clockQualifierN |=> dataOe == 32'h0;
  endproperty
  a_write_off: assert property (p_write_off) else $error("drive after write");
  property p_desel_off; load && !sel ##1 !clockQualifierN |=> dataOe == 32'h0; endproperty
  a_desel_off: assert property (p_desel_off) else $error("drive after deselect");
  property p_emerge_off; load && !sel ##1 load && sel |=> dataOe == 32'h0; endproperty
  a_emerge_off: assert property (p_emerge_off) else $error("drive leaving deselect");
  property p_turnaround;
    load && sel && writeStrobeN ##1 load && sel && !writeStrobeN ##1 !clockQualifierN
      |-> (outputDriveN || dataOe == '1) ##1 dataOe == 32'h0;
  endproperty
  a_turnaround: assert property (p_turnaround) else $error("read to write turnaround");
  property p_stall_hold; clockQualifierN && quiet |=> $stable(dataOut); endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("output moved in stall");
  property p_sleep_off; sleepRequest [*5] |-> dataOe == 32'h0; endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("drive while asleep");
  // main traffic seen
  c_read: cover property (load && sel && writeStrobeN);
  c_write: cover property (load && sel && !writeStrobeN);
  c_stall: cover property (clockQualifierN ##1 clockQualifierN);
endmodule : pbs_sram_port_props
`default_nettype wire

// >>> bench/pbs_ctl_model.sv
// controller-side model that owns the write half of the shared data lines
`timescale 1ns/1ps
`default_nettype none
module pbs_ctl_model
(
  // clock and stall
  input wire logic ref_clk,
  input wire logic clockQualifierN,
  // write beat issued this cycle
  input wire logic wrBeat,
  input wire logic [35:0] wrWord,
  // lines seen by the device
  output logic [31:0] dataIn,
  output logic [3:0] parityLaneIn
);
  logic [36:0] stage1 = 37'h0;
  logic [36:0] stage2 = 37'h0;
  logic [35:0] last = 36'h0;
  // data follows its beat by two qualified edges; stalls hold the pipe
  always @(posedge ref_clk)
    if (!clockQualifierN)
    begin
      stage1 <= {wrBeat, wrWord};
      stage2 <= stage1;
    end
  // remember the driven word so a released line never repeats it
  always @(posedge ref_clk)
    if (stage2[36])
      last <= stage2[35:0];
  // drive the word in the data window and the inverse of the last word outside it
  assign {parityLaneIn, dataIn} = stage2[36] ? stage2[35:0] : ~last;
endmodule : pbs_ctl_model
`default_nettype wire

// >>> bench/test_pipelined_sync_burst_sram_port.sv
// self-checking bench for the pipelined burst sram port
`timescale 1ns/1ps
`default_nettype none
module test_pipelined_sync_burst_sram_port;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [18:0] addrIn = 19'h0;
  logic clockQualifierN = 1'b0;
  logic chipSelect1N = 1'b1;
  logic chipSelect2 = 1'b1;
  logic chipSelect3N = 1'b0;
  logic writeStrobeN = 1'b1;
  logic stepOrCapture = 1'b0;
  logic [3:0] byteLaneSelectN = 4'hf;
  logic burstOrderSelect = 1'b1;
  logic outputDriveN = 1'b0;
  logic sleepRequest = 1'b0;
  logic wrBeat = 1'b0;
  logic [35:0] wrWord = 36'h0;
  logic [31:0] dataIn, dataOut, dataOe;
  logic [3:0] parityLaneIn, parityLaneOut, parityLaneOe;
  logic [35:0] shadow [logic [18:0]];
  logic [18:0] bAddr = 19'h0;
  logic [1:0] bBeat = 2'h0;
  logic bWr = 1'b0;
  logic bAct = 1'b0;
  logic pendV = 1'b0;
  logic shownV = 1'b0;
  logic [35:0] pendD = 36'h0;
  logic [35:0] shownD = 36'h0;
  int n_fail = 0;
  int comparisons = 0;
  pbs_sram_port uut (.ref_clk, .rst_b, .addrIn, .clockQualifierN, .chipSelect1N, .chipSelect2,
    .chipSelect3N, .writeStrobeN, .stepOrCapture, .byteLaneSelectN, .burstOrderSelect,
    .outputDriveN, .sleepRequest, .dataIn, .dataOut, .dataOe, .parityLaneIn, .parityLaneOut,
    .parityLaneOe);
  pbs_ctl_model partner (.ref_clk, .clockQualifierN, .wrBeat, .wrWord, .dataIn, .parityLaneIn);
  //////////////////////////////
  // 125 MHz clock
  initial forever #4 ref_clk = ~ref_clk;
  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one cycle: 0 read, 1 write, 2 next beat, 3 deselect, 4 stall; checks the pins after it
  task automatic op(input int k, input logic [18:0] a, input logic [3:0] ln, input logic [35:0] d);
    logic [18:0] ea;
    logic nv;
    clockQualifierN = (k == 4);
    stepOrCapture = (k == 2);
    chipSelect1N = (k >= 2);
    writeStrobeN = (k != 1);
    addrIn = a;
    byteLaneSelectN = ln;
    wrWord = d;
    if (k < 2)
    begin
      bAddr = a;
      bBeat = 2'h0;
      bWr = (k == 1);
      bAct = 1'b1;
    end
    else if (k == 2 && bAct)
      bBeat++;
    else if (k == 3)
      bAct = 1'b0;
    ea = {bAddr[18:2], burstOrderSelect ? bAddr[1:0] ^ bBeat : bAddr[1:0] + bBeat};
    wrBeat = bAct && bWr && k < 3;
    nv = bAct && !bWr && k < 3;
    for (int i = 0; i < 4; i++)
      if (wrBeat && !ln[i])
      begin
        shadow[ea][8*i+:8] = d[8*i+:8];
        shadow[ea][32+i] = d[32+i];
      end
    @(posedge ref_clk);
    #1;
    if (k != 4)
    begin
      shownV = pendV;
      shownD = pendD;
      pendV = nv;
      pendD = nv ? shadow[ea] : 36'h0;
    end
    chk({parityLaneOe, dataOe}, {36{shownV && !outputDriveN}});
    if (shownV)
      chk({parityLaneOut, dataOut}, shownD);
  endtask : op
  task automatic ds(input int n);
    repeat (n) op(3, 19'h0, 4'hf, 36'h0);
  endtask : ds
  //////////////////////////////
  // partial write over a full word, back-to-back reads, write straight after a read
  task automatic lanes_case;
    op(1, 19'h00005, 4'h0, 36'h9a1b2c3d4);
    op(1, 19'h00005, 4'ha, 36'h0ffeeddcc);
    ds(2);
    op(0, 19'h00005, 4'hf, 36'h0);
    op(0, 19'h00005, 4'hf, 36'h0);
    op(1, 19'h00006, 4'h0, 36'h123456789);
    ds(2);
    op(0, 19'h00006, 4'hf, 36'h0);
    ds(2);
  endtask : lanes_case
  // burst write from an odd start, continue beats with selects off, singles read back
  task automatic burst_case(input logic mode);
    burstOrderSelect = mode;
    ds(3);
    op(1, 19'h00011, 4'h0, 36'h5a5a00000 + 8 * mode);
    for (int b = 1; b < 4; b++)
      op(2, 19'h7ffff, 4'h0, 36'h5a5a00000 + 8 * mode + b);
    ds(2);
    op(2, 19'h0, 4'h0, 36'h0);
    for (int a = 0; a < 4; a++)
      op(0, 19'h00010 + a, 4'hf, 36'h0);
    op(0, 19'h00012, 4'hf, 36'h0);
    for (int b = 1; b < 6; b++)
      op(2, 19'h0, 4'hf, 36'h0);
    ds(2);
  endtask : burst_case
  // drive enable held off, then stalls across a read and across a write's data phase
  task automatic stall_case;
    outputDriveN = 1'b1;
    op(0, 19'h00005, 4'hf, 36'h0);
    ds(1);
    outputDriveN = 1'b0;
    op(4, 19'h0, 4'hf, 36'h0);
    op(4, 19'h0, 4'hf, 36'h0);
    op(1, 19'h00007, 4'h0, 36'h1c0c0c0c0);
    op(4, 19'h0, 4'hf, 36'h0);
    op(4, 19'h0, 4'hf, 36'h0);
    ds(2);
    op(0, 19'h00007, 4'hf, 36'h0);
    ds(2);
  endtask : stall_case
  // sleep while deselected, recover, contents still there
  task automatic sleep_case;
    ds(1);
    sleepRequest = 1'b1;
    ds(8);
    sleepRequest = 1'b0;
    ds(5);
    op(0, 19'h00005, 4'hf, 36'h0);
    ds(2);
  endtask : sleep_case
  //////////////////////////////
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  // the whole run is under a microsecond, so this only cuts a hang
  initial
  begin
    #20000;
    n_fail++;
    complete_run();
  end
  // main sequence
  initial
  begin
    repeat (10) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    chk({parityLaneOe, dataOe}, 36'h0);
    lanes_case();
    burst_case(1'b0);
    burst_case(1'b1);
    stall_case();
    sleep_case();
    complete_run();
  end
endmodule : test_pipelined_sync_burst_sram_port
bind pbs_sram_port pbs_sram_port_props chk_i (.ref_clk, .rst_b, .clockQualifierN,
  .chipSelect1N, .chipSelect2, .chipSelect3N, .writeStrobeN, .stepOrCapture, .outputDriveN,
  .sleepRequest, .dataOut, .dataOe, .parityLaneOe);
`default_nettype wire
